// [hw/spc_defines.svh]
// Purpose: constants for the serial control port configuration registers
// Assumes: 13-bit register addresses, 8-bit registers
// Notes: offsets are byte addresses on the serial port
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

`define SPC_ADDR_W 13
`define SPC_ADDR_CFG 13'h000
`define SPC_ADDR_VARIANT 13'h003
`define SPC_ADDR_RBSEL 13'h004
`define SPC_ADDR_PDSYNC 13'h230
`define SPC_ADDR_RSVD 13'h231
`define SPC_ADDR_UPDATE 13'h232

`define SPC_CFG_DEFAULT 8'h18
`define SPC_CFG_LONG 3
`define SPC_CFG_SRST 2
`define SPC_CFG_LSB 1
`define SPC_CFG_UNI 0

`define SPC_RBSEL_DEFAULT 1'b0
`define SPC_RBSEL_BIT 0
`define SPC_PDS_DEFAULT 3'h0
`define SPC_PDS_SOFT_SYNC 0
`define SPC_PDS_PD_DIST 1
`define SPC_PDS_PD_SYNC 2
`define SPC_UPDATE_BIT 0

`define SPC_INST_LONG_LAST 4'hf
`define SPC_INST_SHORT_LAST 4'h7
`define SPC_BYTE_LAST 4'h7
`define SPC_LEN_STREAM 2'h3
`define SPC_LI_RW 15
`define SPC_LI_LEN_HI 14
`define SPC_LI_LEN_LO 13
`define SPC_LI_ADDR_HI 12
`define SPC_SI_RW 7
`define SPC_SI_LEN_HI 6
`define SPC_SI_LEN_LO 5
`define SPC_SI_ADDR_HI 4
`define SPC_PDS_HI 2

`endif

// [hw/spc_pkg.sv]
// Purpose: types for the serial control port
// Assumes: nothing
// Notes: states of the transfer sequencer
package spc_pkg;
    typedef enum logic [1:0] {
        ST_INST = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ = 2'b10,
        ST_DONE = 2'b11
    } port_state_t;
endpackage

// [hw/serial_port_config_regs.sv]
// Purpose: serial control port with configuration and system control registers
// Assumes: serial pins are asynchronous to I_SYS_CLK and sclk is well below clk/4
// Notes: data sampled on rising sclk, read data launched on falling sclk
// Overview of operation
// - instruction bit zero short, one long
// - soft reset holds defaults, never self-clears
// - bit order selects shift order, address step
// - mode zero: shared data pin, separate hi-z
// - mode one: reads on separate output pin
// - read-only variant code, writes ignored
// - readback select picks buffer or active
`timescale 1ns/1ps
`include "spc_defines.svh"

module serial_port_config_regs #(
    parameter logic [7:0] VARIANT_CODE = 8'h5a // arbitrary value
) (
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic I_SDIO,
    output logic O_SDIO,
    output logic O_SDIO_OE_N,
    output logic O_SEPARATE_SERIAL_OUT_PIN,
    output logic O_SEPARATE_SERIAL_OUT_PIN_OE_N,
    output logic O_SOFT_RESET,
    output logic O_SOFT_SYNC,
    output logic O_PD_DIST_REF,
    output logic O_PD_SYNC
);
    logic [2:0] sclk_q;
    logic [2:0] cs_n_q;
    logic [1:0] sdio_q;
    logic rise;
    logic fall;
    logic cs_act;
    spc_pkg::port_state_t state_q;
    logic [3:0] cnt_q;
    logic [15:0] sr_q;
    logic [15:0] sr_d;
    logic [15:0] inst;
    logic [`SPC_ADDR_W-1:0] addr_q;
    logic [`SPC_ADDR_W-1:0] step_addr;
    logic [`SPC_ADDR_W-1:0] inst_addr;
    logic [`SPC_ADDR_W-1:0] ld_addr;
    logic [1:0] left_q;
    logic stream_q;
    logic inst_rd;
    logic [1:0] inst_len;
    logic [3:0] inst_last;
    logic inst_done;
    logic byte_done;
    logic last_byte;
    logic [7:0] byte_w;
    logic wr_en;
    logic ld_rd;
    logic [7:0] rd_data;
    logic [7:0] tx_q;
    logic out_q;
    logic sdio_oe_n_q;
    logic sep_oe_n_q;
    logic [7:0] cfg_q;
    logic rbsel_q;
    logic [2:0] buf_q;
    logic [2:0] act_q;
    logic upd_q;
    logic lsb;
    logic long_i;

    assign lsb = cfg_q[`SPC_CFG_LSB];
    assign long_i = cfg_q[`SPC_CFG_LONG];

    // two-stage synchronisers, third stage only for edge detect
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sclk_q <= 3'h0;
            cs_n_q <= 3'h7;
            sdio_q <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], I_SCLK};
            cs_n_q <= {cs_n_q[1:0], I_CS_N};
            sdio_q <= {sdio_q[0], I_SDIO};
        end
    end

    assign rise = sclk_q[1] && !sclk_q[2];
    assign fall = !sclk_q[1] && sclk_q[2];
    assign cs_act = !cs_n_q[1];

    always_comb begin
        sr_d = lsb ? {sdio_q[1], sr_q[15:1]} : {sr_q[14:0], sdio_q[1]};
        byte_w = lsb ? sr_d[15:8] : sr_d[7:0];
        if (long_i) begin
            inst = sr_d;
            inst_rd = inst[`SPC_LI_RW];
            inst_len = inst[`SPC_LI_LEN_HI:`SPC_LI_LEN_LO];
            inst_addr = inst[`SPC_LI_ADDR_HI:0];
            inst_last = `SPC_INST_LONG_LAST;
        end else begin
            inst = {8'h00, byte_w};
            inst_rd = inst[`SPC_SI_RW];
            inst_len = inst[`SPC_SI_LEN_HI:`SPC_SI_LEN_LO];
            inst_addr = {8'h00, inst[`SPC_SI_ADDR_HI:0]};
            inst_last = `SPC_INST_SHORT_LAST;
        end
    end

    // address steps down in msb-first mode and up in lsb-first mode
    assign step_addr = lsb ? addr_q + 1'b1 : addr_q - 1'b1;
    assign inst_done = rise && cs_act && state_q == spc_pkg::ST_INST && cnt_q == inst_last;
    assign byte_done = rise && cs_act && cnt_q == `SPC_BYTE_LAST
        && (state_q == spc_pkg::ST_WRITE || state_q == spc_pkg::ST_READ);
    assign last_byte = !stream_q && left_q == 2'h0;
    assign wr_en = byte_done && state_q == spc_pkg::ST_WRITE;
    assign ld_rd = (inst_done && inst_rd) || (byte_done && state_q == spc_pkg::ST_READ && !last_byte);
    assign ld_addr = (state_q == spc_pkg::ST_INST) ? inst_addr : step_addr;

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_q <= spc_pkg::ST_INST;
            cnt_q <= 4'h0;
            sr_q <= 16'h0000;
            addr_q <= `SPC_ADDR_CFG;
            left_q <= 2'h0;
            stream_q <= 1'b0;
        end else if (!cs_act) begin
            state_q <= spc_pkg::ST_INST;
            cnt_q <= 4'h0;
        end else if (rise) begin
            sr_q <= sr_d;
            cnt_q <= cnt_q + 4'h1;
            unique case (state_q)
                spc_pkg::ST_INST: begin
                    if (inst_done) begin
                        cnt_q <= 4'h0;
                        addr_q <= inst_addr;
                        left_q <= inst_len;
                        stream_q <= inst_len == `SPC_LEN_STREAM;
                        state_q <= inst_rd ? spc_pkg::ST_READ : spc_pkg::ST_WRITE;
                    end
                end
                spc_pkg::ST_WRITE, spc_pkg::ST_READ: begin
                    if (byte_done) begin
                        cnt_q <= 4'h0;
                        addr_q <= step_addr;
                        left_q <= left_q - 2'h1;
                        if (last_byte) begin
                            state_q <= spc_pkg::ST_DONE;
                        end
                    end
                end
                spc_pkg::ST_DONE: begin
                    cnt_q <= 4'h0;
                end
            endcase
        end
    end

    always_comb begin
        unique case (ld_addr)
            `SPC_ADDR_CFG: rd_data = cfg_q;
            `SPC_ADDR_VARIANT: rd_data = VARIANT_CODE;
            `SPC_ADDR_RBSEL: rd_data = {7'h00, rbsel_q};
            `SPC_ADDR_PDSYNC: rd_data = {5'h00, rbsel_q ? act_q : buf_q};
            `SPC_ADDR_UPDATE: rd_data = {7'h00, upd_q};
            default: rd_data = 8'h00;
        endcase
    end

    // configuration word; soft reset holds defaults until cleared by a write
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cfg_q <= `SPC_CFG_DEFAULT;
        end else if (wr_en && addr_q == `SPC_ADDR_CFG) begin
            cfg_q <= byte_w;
        end else if (cfg_q[`SPC_CFG_SRST]) begin
            cfg_q <= `SPC_CFG_DEFAULT;
            cfg_q[`SPC_CFG_SRST] <= 1'b1;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rbsel_q <= `SPC_RBSEL_DEFAULT;
            buf_q <= `SPC_PDS_DEFAULT;
        end else if (cfg_q[`SPC_CFG_SRST]) begin
            rbsel_q <= `SPC_RBSEL_DEFAULT;
            buf_q <= `SPC_PDS_DEFAULT;
        end else if (wr_en && addr_q == `SPC_ADDR_RBSEL) begin
            rbsel_q <= byte_w[`SPC_RBSEL_BIT];
        end else if (wr_en && addr_q == `SPC_ADDR_PDSYNC) begin
            buf_q <= byte_w[`SPC_PDS_HI:0];
        end
    end

    // update strobe: set wins, self-clears once the copy is done
    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            upd_q <= 1'b0;
            act_q <= `SPC_PDS_DEFAULT;
        end else if (cfg_q[`SPC_CFG_SRST]) begin
            upd_q <= 1'b0;
            act_q <= `SPC_PDS_DEFAULT;
        end else begin
            if (upd_q) begin
                act_q <= buf_q;
            end
            upd_q <= wr_en && addr_q == `SPC_ADDR_UPDATE && byte_w[`SPC_UPDATE_BIT];
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tx_q <= 8'h00;
            out_q <= 1'b0;
        end else if (ld_rd) begin
            tx_q <= rd_data;
        end else if (fall && cs_act && state_q == spc_pkg::ST_READ) begin
            out_q <= lsb ? tx_q[0] : tx_q[7];
            tx_q <= lsb ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sdio_oe_n_q <= 1'b1;
            sep_oe_n_q <= 1'b1;
        end else begin
            sdio_oe_n_q <= !(cs_act && state_q == spc_pkg::ST_READ && !cfg_q[`SPC_CFG_UNI]);
            sep_oe_n_q <= !(cs_act && state_q == spc_pkg::ST_READ && cfg_q[`SPC_CFG_UNI]);
        end
    end

    assign O_SDIO = out_q;
    assign O_SDIO_OE_N = sdio_oe_n_q;
    assign O_SEPARATE_SERIAL_OUT_PIN = out_q;
    assign O_SEPARATE_SERIAL_OUT_PIN_OE_N = sep_oe_n_q;
    assign O_SOFT_RESET = cfg_q[`SPC_CFG_SRST];
    assign O_SOFT_SYNC = act_q[`SPC_PDS_SOFT_SYNC];
    assign O_PD_DIST_REF = act_q[`SPC_PDS_PD_DIST];
    assign O_PD_SYNC = act_q[`SPC_PDS_PD_SYNC];

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);

    a_short_inst_len: assert property (
        (rise && cs_act && state_q == spc_pkg::ST_INST && !long_i && cnt_q == `SPC_INST_SHORT_LAST)
        |=> state_q != spc_pkg::ST_INST || !cs_act)
        else $error("short instruction not ended after 8 bits");
    a_long_inst_len: assert property (
        (rise && cs_act && state_q == spc_pkg::ST_INST && long_i && cnt_q == `SPC_BYTE_LAST)
        |=> state_q == spc_pkg::ST_INST)
        else $error("long instruction ended after 8 bits");
    a_soft_reset_hold: assert property (
        (cfg_q[`SPC_CFG_SRST] && !wr_en)
        |=> cfg_q[`SPC_CFG_SRST] && buf_q == `SPC_PDS_DEFAULT && rbsel_q == `SPC_RBSEL_DEFAULT
        && act_q == `SPC_PDS_DEFAULT)
        else $error("soft reset not holding defaults");
    a_addr_step: assert property (
        (byte_done && lsb)
        |=> addr_q == $past(addr_q) + 13'h1)
        else $error("lsb-first address did not increment");
    a_bidir_hiz: assert property (
        (!cfg_q[`SPC_CFG_UNI]) |=> O_SEPARATE_SERIAL_OUT_PIN_OE_N)
        else $error("separate output driven in bidirectional mode");
    a_uni_sdio_in: assert property (
        (cfg_q[`SPC_CFG_UNI]) |=> O_SDIO_OE_N)
        else $error("data pin driven in unidirectional mode");
    a_variant_ro: assert property (
        (ld_rd && ld_addr == `SPC_ADDR_VARIANT) |=> tx_q == VARIANT_CODE)
        else $error("variant code read wrong");
    a_readback_src: assert property (
        (ld_rd && ld_addr == `SPC_ADDR_PDSYNC)
        |=> tx_q[2:0] == ($past(rbsel_q) ? $past(act_q) : $past(buf_q)))
        else $error("readback source wrong");
    a_update_copy: assert property (
        (upd_q && !cfg_q[`SPC_CFG_SRST] && !wr_en)
        |=> act_q == $past(buf_q) && !upd_q)
        else $error("update did not copy or clear");
    a_addr_step_down: assert property (
        (byte_done && !lsb)
        |=> addr_q == $past(addr_q) - 13'h1)
        else $error("msb-first address did not decrement");
    a_soft_reset_kept: assert property (
        (cfg_q[`SPC_CFG_SRST] && !(wr_en && addr_q == `SPC_ADDR_CFG))
        |=> cfg_q[`SPC_CFG_SRST])
        else $error("soft reset cleared itself");
    a_idle_pins_off: assert property (
        (!cs_act) |=> O_SDIO_OE_N && O_SEPARATE_SERIAL_OUT_PIN_OE_N)
        else $error("data pin driven outside a frame");
    a_update_set: assert property (
        (wr_en && addr_q == `SPC_ADDR_UPDATE && byte_w[`SPC_UPDATE_BIT] && !cfg_q[`SPC_CFG_SRST])
        |=> upd_q)
        else $error("update write not taken");

    c_read_xfer: cover property (ld_rd ##[1:300] (fall && state_q == spc_pkg::ST_READ));
    c_update: cover property (upd_q ##1 !upd_q);
    c_soft_reset: cover property (cfg_q[`SPC_CFG_SRST] ##[1:1000] !cfg_q[`SPC_CFG_SRST]);
    c_uni_read: cover property (!O_SEPARATE_SERIAL_OUT_PIN_OE_N);
    c_stream_read: cover property (stream_q && byte_done && state_q == spc_pkg::ST_READ);
endmodule // serial_port_config_regs

// [testbench/host_model.sv]
// Purpose: host controller driving the serial control port
// Assumes: sclk half period of 6 system clocks, long instruction form only
// Notes: read bytes are reported with a pin-ok flag in bit 8
`timescale 1ns/1ps

module host_model (
    input wire logic clk,
    input wire logic o_sdio,
    input wire logic o_sdio_oe_n,
    input wire logic o_sep,
    input wire logic o_sep_oe_n,
    output logic sclk,
    output logic cs_n,
    output logic sdio_line,
    output logic rd_valid,
    output logic [8:0] rd_res
);
    logic drv_q;
    logic sep_q;

    // released line flips so a stale bit never passes for data
    assign sdio_line = o_sdio_oe_n ? drv_q : o_sdio;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        drv_q = 1'b0;
        sep_q = 1'b0;
        rd_valid = 1'b0;
        rd_res = '0;
    end

    task automatic bit_cycle(input logic d, output logic q, output logic ok);
        @(posedge clk);
        drv_q <= d;
        repeat (5) @(posedge clk);
        q = sep_q ? o_sep : sdio_line;
        ok = sep_q ? (!o_sep_oe_n && o_sdio_oe_n) : (!o_sdio_oe_n && o_sep_oe_n);
        sclk <= 1'b1;
        repeat (6) @(posedge clk);
        sclk <= 1'b0;
    endtask

    task automatic xfer(input logic rd, input logic [12:0] addr, input logic [1:0] len,
                        input logic [15:0] wd, input logic lsb, input logic sep);
        logic [15:0] ins;
        logic [7:0] b;
        logic q;
        logic ok;
        logic all_ok;
        ins = {rd, len, addr};
        sep_q = sep;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 0; i < 16; i++) bit_cycle(ins[lsb ? i : 15 - i], q, ok);
        for (int k = 0; k <= int'(len); k++) begin
            b = (k != 0) ? wd[15:8] : wd[7:0];
            all_ok = 1'b1;
            for (int i = 0; i < 8; i++) begin
                bit_cycle(rd ? ~drv_q : b[lsb ? i : 7 - i], q, ok);
                if (rd) b[lsb ? i : 7 - i] = q;
                all_ok = all_ok & ok;
            end
            if (rd) begin
                @(posedge clk);
                rd_res <= {all_ok, b};
                rd_valid <= 1'b1;
                @(posedge clk);
                rd_valid <= 1'b0;
            end
        end
        @(posedge clk);
        cs_n <= 1'b1;
        drv_q <= ~drv_q;
        repeat (6) @(posedge clk);
    endtask
endmodule // host_model

// [testbench/test_serial_port_config_regs.sv]
// Purpose: self-checking bench for the serial port configuration registers
// Assumes: host model frames, 10 MHz system clock
// Notes: reads queue their expected bytes, a monitor compares on arrival
`timescale 1ns/1ps
`include "spc_defines.svh"

module test_serial_port_config_regs;
    localparam logic [7:0] VAR = 8'h5a; // arbitrary value
    logic clk, nrst, sclk, cs_n, sdio, o_sdio, sdio_oe_n, sep, sep_oe_n;
    logic srst, ssync, pd_dist, pd_sync, rd_valid, lsb, sep_mode;
    logic [8:0] rd_res;
    logic [8:0] exp_q[$];
    logic [31:0] r;
    logic [2:0] pd;
    int n_mismatch = 0;
    int check_count = 0;

    serial_port_config_regs #(.VARIANT_CODE(VAR)) dut_u (.I_SYS_CLK(clk), .I_NRST(nrst), .I_SCLK(sclk),
        .I_CS_N(cs_n), .I_SDIO(sdio), .O_SDIO(o_sdio), .O_SDIO_OE_N(sdio_oe_n),
        .O_SEPARATE_SERIAL_OUT_PIN(sep), .O_SEPARATE_SERIAL_OUT_PIN_OE_N(sep_oe_n),
        .O_SOFT_RESET(srst), .O_SOFT_SYNC(ssync), .O_PD_DIST_REF(pd_dist), .O_PD_SYNC(pd_sync));
    host_model host_u (.clk(clk), .o_sdio(o_sdio), .o_sdio_oe_n(sdio_oe_n), .o_sep(sep),
        .o_sep_oe_n(sep_oe_n), .sclk(sclk), .cs_n(cs_n), .sdio_line(sdio), .rd_valid(rd_valid),
        .rd_res(rd_res));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [7:0] mirror(input logic [3:0] n);
        return {n[0], n[1], n[2], n[3], n};
    endfunction

    task automatic cmp_byte(input logic [8:0] got, input logic [8:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pins(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected pins at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        host_u.xfer(1'b0, a, 2'h0, {8'h00, d}, lsb, sep_mode);
    endtask

    task automatic rd(input logic [12:0] a, input logic [1:0] len, input logic [15:0] e);
        exp_q.push_back({1'b1, e[7:0]});
        if (len != 2'h0) exp_q.push_back({1'b1, e[15:8]});
        host_u.xfer(1'b1, a, len, 16'h0000, lsb, sep_mode);
    endtask

    task automatic rd_stream(input logic [12:0] a, input logic [31:0] e);
        for (int k = 0; k < 4; k++) exp_q.push_back({1'b1, e[8*k +: 8]});
        host_u.xfer(1'b1, a, `SPC_LEN_STREAM, 16'h0000, lsb, sep_mode);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) begin
        if (rd_valid) begin
            if (exp_q.size() == 0) cmp_byte(rd_res, ~rd_res); // unasked-for byte always counts
            else cmp_byte(rd_res, exp_q.pop_front());
        end
    end

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end

    initial begin
        nrst = 1'b0;
        lsb = 1'b0;
        sep_mode = 1'b0;
        r = $urandom(11864);
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        cmp_pins({sdio_oe_n, sep_oe_n, srst, ssync}, 4'hc);
        rd(`SPC_ADDR_CFG, 2'h0, 16'h0018);
        rd(`SPC_ADDR_VARIANT, 2'h0, {8'h00, VAR});
        r = $urandom;
        pd = {r[18:17], 1'b1};
        wr(`SPC_ADDR_VARIANT, r[7:0]);
        wr(`SPC_ADDR_RSVD, r[15:8]);
        rd(`SPC_ADDR_VARIANT, 2'h0, {8'h00, VAR});
        rd(`SPC_ADDR_RSVD, 2'h0, 16'h0000);
        rd(`SPC_ADDR_RBSEL, 2'h0, 16'h0000);
        wr(`SPC_ADDR_PDSYNC, {5'h00, pd});
        rd(`SPC_ADDR_PDSYNC, 2'h0, {13'h0000, pd});
        cmp_pins({1'b0, pd_sync, pd_dist, ssync}, 4'h0);
        wr(`SPC_ADDR_RBSEL, 8'h01);
        rd(`SPC_ADDR_PDSYNC, 2'h0, 16'h0000);
        wr(`SPC_ADDR_UPDATE, 8'h01);
        repeat (4) @(posedge clk);
        cmp_pins({1'b0, pd_sync, pd_dist, ssync}, {1'b0, pd});
        rd(`SPC_ADDR_UPDATE, 2'h0, 16'h0000);
        rd(`SPC_ADDR_PDSYNC, 2'h0, {13'h0000, pd});
        rd(`SPC_ADDR_RBSEL, 2'h1, {VAR, 8'h01});
        wr(`SPC_ADDR_CFG, mirror(4'b1001));
        sep_mode = 1'b1;
        rd(`SPC_ADDR_CFG, 2'h0, 16'h0099);
        wr(`SPC_ADDR_CFG, mirror(4'b1000));
        sep_mode = 1'b0;
        wr(`SPC_ADDR_CFG, mirror(4'b1010));
        lsb = 1'b1;
        rd(`SPC_ADDR_VARIANT, 2'h1, {8'h01, VAR});
        rd(`SPC_ADDR_CFG, 2'h0, 16'h005a);
        rd_stream(`SPC_ADDR_CFG, {VAR, 8'h00, 8'h00, 8'h5a});
        wr(`SPC_ADDR_CFG, mirror(4'b1100));
        lsb = 1'b0;
        repeat (20) @(posedge clk);
        cmp_pins({srst, pd_sync, pd_dist, ssync}, 4'h8);
        rd(`SPC_ADDR_RBSEL, 2'h0, 16'h0000);
        cmp_pins({srst, 3'h0}, 4'h8);
        wr(`SPC_ADDR_CFG, mirror(4'b1000));
        cmp_pins({srst, sdio_oe_n, sep_oe_n, 1'b0}, 4'h6);
        rd(`SPC_ADDR_PDSYNC, 2'h0, 16'h0000);
        for (int i = 0; i < 100 && exp_q.size() != 0; i++) @(posedge clk);
        if (exp_q.size() != 0) n_mismatch++;
        finish_test();
    end
endmodule // test_serial_port_config_regs
